// [bench/psa_issuer.sv]
`timescale 1ns/1ps
module psa_issuer
    import psa_pkg::*;
(
    input wire logic ref_clk,
    output logic issueValid,
    output logic [15:0] opcode,
    output logic [7:0] modrm,
    output logic [63:0] memData,
    output logic loadValid,
    output logic [2:0] loadIndex,
    output logic [63:0] loadData
);
    initial begin
        issueValid = 1'b0;
        opcode = 16'h0;
        modrm = 8'h0;
        memData = 64'h0;
        loadValid = 1'b0;
        loadIndex = 3'h0;
        loadData = 64'h0;
    end

    // top field 11 names a register pair, else memData is the source
    task automatic present(input logic [15:0] opc, input logic [7:0] m,
                           input logic [63:0] mem);
        @(posedge ref_clk);
        issueValid <= 1'b1;
        opcode <= opc;
        modrm <= m;
        memData <= mem;
    endtask

    task automatic put_load(input logic [2:0] idx, input logic [63:0] d);
        loadValid <= 1'b1;
        loadIndex <= idx;
        loadData <= d;
    endtask

    // released lines flip so a stale value never looks valid
    task automatic idle();
        @(posedge ref_clk);
        issueValid <= 1'b0;
        loadValid <= 1'b0;
        opcode <= ~opcode;
        modrm <= ~modrm;
        memData <= ~memData;
        loadIndex <= ~loadIndex;
        loadData <= ~loadData;
    endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb
    import psa_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] readIndex = 3'h0;
    logic issueValid, loadValid, resultValid, illegalOp;
    logic [15:0] opcode;
    logic [7:0] modrm;
    logic [63:0] memData, loadData, readData, resultData;
    logic [2:0] loadIndex, resultIndex;
    logic [63:0] shadow [8];
    int err_total = 0;
    int samples_checked = 0;
    localparam logic [63:0] VA = 64'h7F80FF0180007FFF;
    localparam logic [63:0] VB = 64'h7F7F010180000001;
    localparam logic [63:0] VM = 64'h7F80FF0100FF8001;
    localparam logic [15:0] OPCS [15] = '{OPC_ADD_BYTE_WRAP,
        OPC_ADD_WORD_WRAP, OPC_ADD_DWORD_WRAP, OPC_ADD_SBYTE_SAT,
        OPC_ADD_SWORD_SAT, OPC_ADD_UBYTE_SAT, OPC_ADD_UWORD_SAT, OPC_AND,
        OPC_AND_INV, OPC_EQ_BYTE, OPC_EQ_WORD, OPC_EQ_DWORD, OPC_GT_BYTE,
        OPC_GT_DWORD, OPC_NARROW};

    always #5 ref_clk = ~ref_clk;

    psa_issuer u_iss (.ref_clk(ref_clk), .issueValid(issueValid),
        .opcode(opcode), .modrm(modrm), .memData(memData),
        .loadValid(loadValid), .loadIndex(loadIndex), .loadData(loadData));

    psa_datapath u_dut (.ref_clk(ref_clk), .rst(rst),
        .issueValid(issueValid), .opcode(opcode), .modrm(modrm),
        .memData(memData), .loadValid(loadValid), .loadIndex(loadIndex),
        .loadData(loadData), .readIndex(readIndex), .readData(readData),
        .resultValid(resultValid), .resultIndex(resultIndex),
        .resultData(resultData), .illegalOp(illegalOp));

    function automatic logic [63:0] ref_op(input logic [15:0] opc,
                                          input logic [63:0] d, s);
        int w;
        int k;
        longint a, b, x, hi;
        logic [63:0] r, m, src;
        r = 64'h0;
        case (opc)
            OPC_ADD_WORD_WRAP, OPC_ADD_SWORD_SAT, OPC_ADD_UWORD_SAT,
            OPC_EQ_WORD: w = 16;
            OPC_ADD_DWORD_WRAP, OPC_EQ_DWORD, OPC_GT_DWORD: w = 32;
            default: w = 8;
        endcase
        case (opc)
            OPC_ADD_SBYTE_SAT, OPC_ADD_SWORD_SAT: k = 1;
            OPC_ADD_UBYTE_SAT, OPC_ADD_UWORD_SAT: k = 2;
            OPC_EQ_BYTE, OPC_EQ_WORD, OPC_EQ_DWORD: k = 3;
            OPC_GT_BYTE, OPC_GT_DWORD: k = 4;
            default: k = 0;
        endcase
        if (opc == OPC_AND) return d & s;
        if (opc == OPC_AND_INV) return ~d & s;
        if (opc == OPC_NARROW) begin
            for (int i = 0; i < 8; i++) begin
                src = (i < 4) ? d : s;
                x = longint'($signed(src[16*(i%4) +: 16]));
                x = (x < 0) ? 0 : ((x > 255) ? 255 : x);
                r[8*i +: 8] = x[7:0];
            end
            return r;
        end
        m = (64'h1 << w) - 64'h1;
        hi = (longint'(1) << (w - 1)) - 1;
        for (int i = 0; i < 64 / w; i++) begin
            a = longint'((d >> (i * w)) & m);
            b = longint'((s >> (i * w)) & m);
            if ((k == 1 || k == 4) && a[w-1]) a -= longint'(1) << w;
            if ((k == 1 || k == 4) && b[w-1]) b -= longint'(1) << w;
            x = a + b;
            if (k == 1) x = (x > hi) ? hi : ((x < -hi - 1) ? -hi - 1 : x);
            if (k == 2 && x > longint'(m)) x = longint'(m);
            if (k == 3) x = (a == b) ? -1 : 0;
            if (k == 4) x = (a > b) ? -1 : 0;
            r = r | ((64'(x) & m) << (i * w));
        end
        return r;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked,
                 err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic load(input logic [2:0] idx, input logic [63:0] d);
        @(posedge ref_clk);
        u_iss.put_load(idx, d);
        u_iss.idle();
        shadow[idx] = d;
    endtask

    task automatic op(input logic [15:0] opc, input logic [7:0] m,
                      input logic [63:0] mem);
        logic [63:0] e;
        e = ref_op(opc, shadow[m[5:3]],
                   (m[7:6] == MODE_REG_FORM) ? shadow[m[2:0]] : mem);
        u_iss.present(opc, m, mem);
        readIndex <= m[5:3];
        u_iss.idle();
        #1;
        shadow[m[5:3]] = e;
        chk(resultValid, 64'h1);
        chk(resultIndex, m[5:3]);
        chk(resultData, e);
        chk(readData, e);
        chk(resultData, e);
        @(posedge ref_clk);
        #1 chk(resultValid, 64'h0);
    endtask

    task automatic s_reset();
        for (int r = 0; r < 8; r++) begin
            @(posedge ref_clk);
            readIndex <= r[2:0];
            #1 chk(readData, 64'h0);
            shadow[r] = 64'h0;
        end
    endtask

    task automatic s_all_ops();
        for (int k = 0; k < 14; k++) begin
            load(1, VA);
            load(2, VB);
            op(OPCS[k], 8'hCA, 64'h0);
        end
        for (int k = 0; k < 15; k++) begin
            load(3, VA);
            op(OPCS[k], 8'h18, VM);
        end
    endtask

    // the second op must see the first op's freshly written result
    task automatic s_back_to_back();
        logic [63:0] e1, e2;
        load(1, VA);
        load(2, VB);
        e1 = ref_op(OPC_ADD_BYTE_WRAP, VA, VB);
        e2 = ref_op(OPC_ADD_WORD_WRAP, shadow[4], e1);
        u_iss.present(OPC_ADD_BYTE_WRAP, 8'hCA, 64'h0);
        u_iss.present(OPC_ADD_WORD_WRAP, 8'hE1, 64'h0);
        #1 chk(resultData, e1);
        u_iss.idle();
        #1 chk(resultData, e2);
        chk(resultIndex, 64'h4);
        shadow[1] = e1;
        shadow[4] = e2;
    endtask

    task automatic s_illegal();
        for (int k = 0; k < 2; k++) begin
            u_iss.present(k == 0 ? 16'h0FFF : OPC_NARROW, 8'hCA, 64'h0);
            readIndex <= 3'h1;
            u_iss.idle();
            #1 chk({resultValid, illegalOp}, 64'h1);
            chk(readData, shadow[1]);
            @(posedge ref_clk);
            #1 chk(illegalOp, 64'h0);
        end
    endtask

    task automatic s_collide();
        u_iss.present(OPC_AND, 8'hEA, 64'h0);
        u_iss.put_load(5, 64'hFFFFFFFFFFFFFFFF);
        readIndex <= 3'h5;
        u_iss.idle();
        #1 chk(readData, shadow[5] & shadow[2]);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset();
        s_all_ops();
        s_back_to_back();
        s_illegal();
        s_collide();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        conclude();
    end
endmodule

// [core/psa_datapath.sv]
`timescale 1ns/1ps
module psa_datapath
    import psa_pkg::*;
#(
    parameter int REG_COUNT = PSA_REG_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire logic [15:0] opcode,
    input wire logic [7:0] modrm,
    input wire logic [63:0] memData,
    input wire logic loadValid,
    input wire logic [2:0] loadIndex,
    input wire logic [63:0] loadData,
    input wire logic [2:0] readIndex,
    output logic [63:0] readData,
    output logic resultValid,
    output logic [2:0] resultIndex,
    output logic [63:0] resultData,
    output logic illegalOp
);
    logic [63:0] regFile [REG_COUNT];

    function automatic psa_op_t decodeOp(input logic [15:0] opc,
                                         input logic regPair);
        case (opc)
            OPC_ADD_BYTE_WRAP: decodeOp = OP_ADDB;
            OPC_ADD_WORD_WRAP: decodeOp = OP_ADDW;
            OPC_ADD_DWORD_WRAP: decodeOp = OP_ADDD;
            OPC_ADD_SBYTE_SAT: decodeOp = OP_ADDSB;
            OPC_ADD_SWORD_SAT: decodeOp = OP_ADDSW;
            OPC_ADD_UBYTE_SAT: decodeOp = OP_ADDUB;
            OPC_ADD_UWORD_SAT: decodeOp = OP_ADDUW;
            OPC_AND: decodeOp = OP_AND;
            OPC_AND_INV: decodeOp = OP_ANDN;
            OPC_EQ_BYTE: decodeOp = OP_EQB;
            OPC_EQ_WORD: decodeOp = OP_EQW;
            OPC_EQ_DWORD: decodeOp = OP_EQD;
            OPC_GT_BYTE: decodeOp = OP_GTB;
            OPC_GT_DWORD: decodeOp = OP_GTD;
            // only the memory-source form of the narrow is built here
            OPC_NARROW: decodeOp = regPair ? OP_NONE : OP_NARROW;
            default: decodeOp = OP_NONE;
        endcase
    endfunction

    // negative words go to zero, anything above a byte to all-ones
    function automatic logic [7:0] narrowWord(input logic [15:0] w);
        if (w[15]) begin
            narrowWord = 8'h00;
        end else if (|w[14:8]) begin
            narrowWord = 8'hFF;
        end else begin
            narrowWord = w[7:0];
        end
    endfunction

    wire logic regPair;
    wire logic [2:0] destIdx;
    wire logic [2:0] srcIdx;
    wire logic [63:0] destOp;
    wire logic [63:0] srcOp;
    wire psa_op_t opSel;
    wire logic accept;

    assign regPair = modrm[MODRM_MODE_HI:MODRM_MODE_LO] == MODE_REG_FORM;
    assign destIdx = modrm[MODRM_REG_HI:MODRM_REG_LO];
    assign srcIdx = modrm[MODRM_RM_HI:MODRM_RM_LO];
    assign destOp = regFile[destIdx];
    assign srcOp = regPair ? regFile[srcIdx] : memData;
    assign opSel = decodeOp(opcode, regPair);
    assign accept = issueValid && (opSel != OP_NONE);
    assign readData = regFile[readIndex];

    wire logic [63:0] bWrap;
    wire logic [63:0] bSSat;
    wire logic [63:0] bUSat;
    wire logic [63:0] bEq;
    wire logic [63:0] bGt;
    wire logic [63:0] wWrap;
    wire logic [63:0] wSSat;
    wire logic [63:0] wUSat;
    wire logic [63:0] wEq;
    wire logic [63:0] dWrap;
    wire logic [63:0] dEq;
    wire logic [63:0] dGt;
    wire logic [63:0] narrowed;

    psa_lane_alu #(.W(PSA_BYTE_W)) u_byte (
        .a(destOp),
        .b(srcOp),
        .wrapSum(bWrap),
        .sSat(bSSat),
        .uSat(bUSat),
        .eqMask(bEq),
        .gtMask(bGt)
    );

    psa_lane_alu #(.W(PSA_WORD_W)) u_word (
        .a(destOp),
        .b(srcOp),
        .wrapSum(wWrap),
        .sSat(wSSat),
        .uSat(wUSat),
        .eqMask(wEq),
        .gtMask()
    );

    psa_lane_alu #(.W(PSA_DWORD_W)) u_dword (
        .a(destOp),
        .b(srcOp),
        .wrapSum(dWrap),
        .sSat(),
        .uSat(),
        .eqMask(dEq),
        .gtMask(dGt)
    );

    // destination words fill the low bytes, source words the high ones
    genvar g;
    for (g = 0; g < 4; g++) begin : g_narrow
        assign narrowed[g*8 +: 8] = narrowWord(destOp[g*16 +: 16]);
        assign narrowed[32+g*8 +: 8] = narrowWord(srcOp[g*16 +: 16]);
    end

    logic [63:0] next_value;

    always_comb begin
        case (opSel)
            OP_ADDB: next_value = bWrap;
            OP_ADDW: next_value = wWrap;
            OP_ADDD: next_value = dWrap;
            OP_ADDSB: next_value = bSSat;
            OP_ADDSW: next_value = wSSat;
            OP_ADDUB: next_value = bUSat;
            OP_ADDUW: next_value = wUSat;
            OP_AND: next_value = destOp & srcOp;
            OP_ANDN: next_value = ~destOp & srcOp;
            OP_EQB: next_value = bEq;
            OP_EQW: next_value = wEq;
            OP_EQD: next_value = dEq;
            OP_GTB: next_value = bGt;
            OP_GTD: next_value = dGt;
            OP_NARROW: next_value = narrowed;
            default: next_value = PSA_REG_RESET;
        endcase
    end

    // an execute write beats a load to the same register in one cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile[i] <= PSA_REG_RESET;
            end
        end else begin
            if (loadValid) begin
                regFile[loadIndex] <= loadData;
            end
            if (accept) begin
                regFile[destIdx] <= next_value;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resultValid <= 1'b0;
            illegalOp <= 1'b0;
            resultIndex <= 3'h0;
            resultData <= PSA_REG_RESET;
        end else begin
            resultValid <= accept;
            illegalOp <= issueValid && !accept;
            if (accept) begin
                resultIndex <= destIdx;
                resultData <= next_value;
            end
        end
    end

    // reference values for the checks below, built apart from the lanes
    wire logic [7:0] refAddB;
    wire logic [15:0] refAddW;
    wire logic [31:0] refAddD;
    wire logic [8:0] refSumUB;
    wire logic [16:0] refSumUW;
    wire logic refPosOvfB;
    wire logic refNegOvfW;
    wire logic [63:0] refAndn;
    wire logic [63:0] refAnd;
    wire logic refEqB;
    wire logic refEqW;
    wire logic refEqD;
    wire logic refGtB;
    wire logic refGtD;
    wire logic [7:0] refNarrow;
    wire logic [7:0] refNarrowLo;
    wire logic [7:0] refAddB7;
    wire logic [63:0] refMemAnd;

    assign refAddB = 8'(destOp[7:0] + srcOp[7:0]);
    assign refAddW = 16'(destOp[63:48] + srcOp[63:48]);
    assign refAddD = 32'(destOp[63:32] + srcOp[63:32]);
    assign refSumUB = {1'b0, destOp[15:8]} + {1'b0, srcOp[15:8]};
    assign refSumUW = {1'b0, destOp[31:16]} + {1'b0, srcOp[31:16]};
    assign refPosOvfB = !destOp[63] && !srcOp[63] && refAddB7[7];
    assign refNegOvfW = destOp[31] && srcOp[31] && !refSumUW[15];
    assign refAndn = srcOp & ~destOp;
    assign refAnd = srcOp & destOp;
    assign refEqB = destOp[23:16] == srcOp[23:16];
    assign refEqW = destOp[47:32] == srcOp[47:32];
    assign refEqD = destOp[31:0] == srcOp[31:0];
    assign refGtB = $signed(destOp[63:56]) > $signed(srcOp[63:56]);
    assign refGtD = $signed(destOp[31:0]) > $signed(srcOp[31:0]);
    assign refNarrow = (srcOp[63:48] > 16'h00FF) ?
                       (srcOp[63] ? 8'h00 : 8'hFF) : srcOp[55:48];
    assign refNarrowLo = (destOp[15:0] > 16'h00FF) ?
                         (destOp[15] ? 8'h00 : 8'hFF) : destOp[7:0];
    // top byte lane, where the stimulus reaches the positive clamp
    assign refAddB7 = 8'(destOp[63:56] + srcOp[63:56]);
    assign refMemAnd = destOp & memData;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence issued(psa_op_t op);
        issueValid && opSel == op;
    endsequence

    sequence answered;
        resultValid ##0 !illegalOp;
    endsequence

    one_clock_a: assert property (
        accept |=> answered ##0 resultIndex == $past(destIdx)
    ) else $error("result not one clock after issue");

    reg_write_a: assert property (
        resultValid |-> regFile[resultIndex] == resultData
    ) else $error("destination register not written");

    addb_wrap_a: assert property (
        issued(OP_ADDB) |=> resultData[7:0] == $past(refAddB)
    ) else $error("byte wrap add wrong");

    addw_wrap_a: assert property (
        issued(OP_ADDW) |=> resultData[63:48] == $past(refAddW)
    ) else $error("word wrap add wrong");

    addd_wrap_a: assert property (
        issued(OP_ADDD) |=> resultData[63:32] == $past(refAddD)
    ) else $error("dword wrap add wrong");

    sbyte_clamp_a: assert property (
        issued(OP_ADDSB) ##0 refPosOvfB |=> resultData[63:56] == 8'h7F
    ) else $error("signed byte not clamped high");

    sword_clamp_a: assert property (
        issued(OP_ADDSW) ##0 refNegOvfW |=> resultData[31:16] == 16'h8000
    ) else $error("signed word not clamped low");

    ubyte_clamp_a: assert property (
        issued(OP_ADDUB) |=> resultData[15:8] ==
            ($past(refSumUB[8]) ? 8'hFF : $past(refSumUB[7:0]))
    ) else $error("unsigned byte clamp wrong");

    uword_clamp_a: assert property (
        issued(OP_ADDUW) |=> resultData[31:16] ==
            ($past(refSumUW[16]) ? 16'hFFFF : $past(refSumUW[15:0]))
    ) else $error("unsigned word clamp wrong");

    and_full_a: assert property (
        issued(OP_AND) |=> resultData == $past(refAnd)
    ) else $error("64-bit and wrong");

    andn_dest_a: assert property (
        issued(OP_ANDN) |=> resultData == $past(refAndn)
    ) else $error("and-not inverts the wrong operand");

    eq_byte_a: assert property (
        issued(OP_EQB) |=> resultData[23:16] ==
            ($past(refEqB) ? 8'hFF : 8'h00)
    ) else $error("byte equal mask wrong");

    eq_word_a: assert property (
        issued(OP_EQW) |=> resultData[47:32] ==
            ($past(refEqW) ? 16'hFFFF : 16'h0000)
    ) else $error("word equal mask wrong");

    eq_dword_a: assert property (
        issued(OP_EQD) |=> resultData[31:0] ==
            ($past(refEqD) ? 32'hFFFFFFFF : 32'h00000000)
    ) else $error("dword equal mask wrong");

    gt_byte_a: assert property (
        issued(OP_GTB) |=> resultData[63:56] ==
            ($past(refGtB) ? 8'hFF : 8'h00)
    ) else $error("signed byte greater mask wrong");

    gt_dword_a: assert property (
        issued(OP_GTD) |=> resultData[31:0] ==
            ($past(refGtD) ? 32'hFFFFFFFF : 32'h00000000)
    ) else $error("signed dword greater mask wrong");

    narrow_sat_a: assert property (
        issued(OP_NARROW) |=> resultData[63:56] == $past(refNarrow)
    ) else $error("word narrow saturation wrong");

    mem_source_a: assert property (
        issued(OP_AND) ##0 !regPair |=> resultData == $past(refMemAnd)
    ) else $error("memory operand not used as source");

    illegal_pulse_a: assert property (
        issueValid && !accept |=> illegalOp && !resultValid
    ) else $error("unknown opcode not flagged");

    load_write_a: assert property (
        loadValid && !(accept && loadIndex == destIdx) |=>
            regFile[$past(loadIndex)] == $past(loadData)
    ) else $error("register load lost");

    op_wins_load_a: assert property (
        accept && loadValid && loadIndex == destIdx |=>
            regFile[$past(destIdx)] == $past(next_value)
    ) else $error("load overrode execute write");

    refused_no_write_a: assert property (
        issueValid && !accept && !loadValid |=>
            regFile[$past(destIdx)] == $past(destOp)
    ) else $error("refused op wrote a register");

    idle_quiet_a: assert property (
        !issueValid |=> !resultValid && !illegalOp
    ) else $error("result pulse without issue");

    result_hold_a: assert property (
        !accept |=> $stable(resultData) && $stable(resultIndex)
    ) else $error("result changed without accepted op");

    narrow_dest_a: assert property (
        issued(OP_NARROW) |=> resultData[7:0] == $past(refNarrowLo)
    ) else $error("destination word narrow wrong");
endmodule

// [core/psa_lane_alu.sv]
`timescale 1ns/1ps
module psa_lane_alu
    import psa_pkg::*;
#(
    parameter int W = PSA_BYTE_W
) (
    input wire logic [63:0] a,
    input wire logic [63:0] b,
    output logic [63:0] wrapSum,
    output logic [63:0] sSat,
    output logic [63:0] uSat,
    output logic [63:0] eqMask,
    output logic [63:0] gtMask
);
    localparam int LANES = PSA_DATA_W / W;

    // overflow shows as the two top bits of the widened sum disagreeing
    function automatic logic [W-1:0] clampSigned(input logic [W:0] s);
        if (s[W] != s[W-1]) begin
            clampSigned = s[W] ? {1'b1, {(W-1){1'b0}}}
                               : {1'b0, {(W-1){1'b1}}};
        end else begin
            clampSigned = s[W-1:0];
        end
    endfunction

    always_comb begin
        logic [W:0] sSum;
        logic [W:0] uSum;
        sSum = '0;
        uSum = '0;
        wrapSum = '0;
        sSat = '0;
        uSat = '0;
        eqMask = '0;
        gtMask = '0;
        for (int i = 0; i < LANES; i++) begin
            uSum = {1'b0, a[i*W +: W]} + {1'b0, b[i*W +: W]};
            sSum = {a[i*W+W-1], a[i*W +: W]} + {b[i*W+W-1], b[i*W +: W]};
            wrapSum[i*W +: W] = uSum[W-1:0];
            sSat[i*W +: W] = clampSigned(sSum);
            uSat[i*W +: W] = uSum[W] ? {W{1'b1}} : uSum[W-1:0];
            eqMask[i*W +: W] = {W{a[i*W +: W] == b[i*W +: W]}};
            gtMask[i*W +: W] =
                {W{$signed(a[i*W +: W]) > $signed(b[i*W +: W])}};
        end
    end
endmodule

// [core/psa_pkg.sv]
// What this block does
// - eight packed registers of 64 bits serve as source and destination.
// - lanes are 8, 16, 32 or 64 bits, all lanes handled at once.
// - opcode 0FFC adds byte lanes with wrap-around, one clock.
// - opcode 0FFD adds word lanes with wrap-around, one clock.
// - opcode 0FFE adds doubleword lanes with wrap-around, one clock.
// - opcode 0FEC adds signed bytes, clamped to signed byte range.
// - opcode 0FED adds signed words, clamped to signed word range.
// - opcode 0FDC adds unsigned bytes, clamped to unsigned byte range.
// - opcode 0FDD adds unsigned words, clamped to unsigned word range.
// - opcode 0FDB writes 64-bit AND of destination and source.
// - opcode 0FDF writes 64-bit AND with one operand inverted.
// - opcode 0F74 gives FFh per equal byte lane, else 00h.
// - opcode 0F75 gives all-ones per equal word lane, else 0000h.
// - opcode 0F76 gives all-ones per equal doubleword lane, else zero.
// - opcode 0F64 gives FFh where destination byte exceeds source byte.
// - opcode 0F66 gives all-ones where destination dword exceeds source.
// - memory form of 0F67 narrows words to bytes, unsigned saturation.
// - mode 11 picks a register pair; else memory is the source.
package psa_pkg;
    localparam int PSA_DATA_W = 64;
    localparam int PSA_REG_COUNT = 8;
    localparam int PSA_IDX_W = 3;
    localparam int PSA_BYTE_W = 8;
    localparam int PSA_WORD_W = 16;
    localparam int PSA_DWORD_W = 32;
    localparam int PSA_LATENCY = 1;
    localparam logic [63:0] PSA_REG_RESET = 64'h0;

    localparam logic [15:0] OPC_ADD_BYTE_WRAP = 16'h0FFC;
    localparam logic [15:0] OPC_ADD_WORD_WRAP = 16'h0FFD;
    localparam logic [15:0] OPC_ADD_DWORD_WRAP = 16'h0FFE;
    localparam logic [15:0] OPC_ADD_SBYTE_SAT = 16'h0FEC;
    localparam logic [15:0] OPC_ADD_SWORD_SAT = 16'h0FED;
    localparam logic [15:0] OPC_ADD_UBYTE_SAT = 16'h0FDC;
    localparam logic [15:0] OPC_ADD_UWORD_SAT = 16'h0FDD;
    localparam logic [15:0] OPC_AND = 16'h0FDB;
    localparam logic [15:0] OPC_AND_INV = 16'h0FDF;
    localparam logic [15:0] OPC_EQ_BYTE = 16'h0F74;
    localparam logic [15:0] OPC_EQ_WORD = 16'h0F75;
    localparam logic [15:0] OPC_EQ_DWORD = 16'h0F76;
    localparam logic [15:0] OPC_GT_BYTE = 16'h0F64;
    localparam logic [15:0] OPC_GT_DWORD = 16'h0F66;
    localparam logic [15:0] OPC_NARROW = 16'h0F67;

    localparam int MODRM_MODE_HI = 7;
    localparam int MODRM_MODE_LO = 6;
    localparam int MODRM_REG_HI = 5;
    localparam int MODRM_REG_LO = 3;
    localparam int MODRM_RM_HI = 2;
    localparam int MODRM_RM_LO = 0;
    localparam logic [1:0] MODE_REG_FORM = 2'h3;

    typedef enum logic [3:0] {
        OP_NONE, OP_ADDB, OP_ADDW, OP_ADDD, OP_ADDSB, OP_ADDSW,
        OP_ADDUB, OP_ADDUW, OP_AND, OP_ANDN, OP_EQB, OP_EQW, OP_EQD,
        OP_GTB, OP_GTD, OP_NARROW
    } psa_op_t;
endpackage
